/* design/cfg_hdr_pkg.sv */
// Purpose: Constants for the configuration header register bank
// Assumes: 32-bit configuration data, word offsets as byte addresses
// Notes:   Shared by the bank and its latency counter
package cfg_hdr_pkg;
	// ----------------------------------------
	// Offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_LAT_CLS   = 8'h0c;
	localparam logic [7:0] OFF_IO_BASE   = 8'h10;
	localparam logic [7:0] OFF_MEM_BASE  = 8'h14;
	localparam logic [7:0] OFF_SUBSYS    = 8'h2c;
	localparam logic [7:0] OFF_ROM_BASE  = 8'h30;
	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int LAT_LSB               = 8;
	localparam int BASE_LSB              = 7;
	localparam int SID_LSB               = 16;
	localparam int ROM_LSB               = 17;
	localparam logic [7:0] LAT_RESET     = 8'h40;
	localparam logic [7:0] CLS_RESET     = 8'h08;
	localparam logic [7:0] CLS_8         = 8'h08;
	localparam logic [7:0] CLS_16        = 8'h10;
	localparam logic [7:0] CLS_32        = 8'h20;
	localparam logic [1:0] ALIGN_NONE    = 2'h0;
	localparam logic [1:0] ALIGN_8       = 2'h1;
	localparam logic [1:0] ALIGN_16      = 2'h2;
	localparam logic [1:0] ALIGN_32      = 2'h3;
	localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
	localparam logic [24:0] BASE_ZERO    = 25'h000_0000;
	localparam logic [14:0] ROM_ZERO     = 15'h0000;
	localparam logic [15:0] SID_ZERO     = 16'h0000;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;

	// Counter states
	typedef enum logic [2:0] {
		LC_IDLE    = 3'b001,
		LC_COUNT   = 3'b010,
		LC_EXPIRED = 3'b100
	} lat_state_t;
endpackage

/* design/bus_hold_counter.sv */
// Purpose: Bus-hold latency counter for master transactions
// Assumes: frame and grant are same-clock levels from the master logic
// Notes:   Asks for termination once expired and grant withdrawn
`timescale 1ns/10ps
module bus_hold_counter (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// Master status
	input  wire logic       frame_active,
	input  wire logic       grant_active,
	input  wire logic [7:0] limit,
	// Result
	output logic            expired,
	output logic            end_request
);
	cfg_hdr_pkg::lat_state_t state_q;
	cfg_hdr_pkg::lat_state_t state_d;
	logic [7:0]              count_q;
	logic [7:0]              count_d;
	wire                     hit;

	assign hit = (count_q + 8'h01) >= limit;

	// --------------------------------------
	// Counting
	// --------------------------------------
	// start on frame
	always_comb begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
		cfg_hdr_pkg::LC_IDLE: begin
			count_d = cfg_hdr_pkg::BYTE_ZERO;
			if (frame_active) begin
				state_d = cfg_hdr_pkg::LC_COUNT;
			end
		end
		cfg_hdr_pkg::LC_COUNT: begin
			count_d = count_q + 8'h01;
			if (!frame_active) begin
				state_d = cfg_hdr_pkg::LC_IDLE;
			end else if (hit) begin
				state_d = cfg_hdr_pkg::LC_EXPIRED;
			end
		end
		cfg_hdr_pkg::LC_EXPIRED: begin
			if (!frame_active) begin
				state_d = cfg_hdr_pkg::LC_IDLE;
			end
		end
		default: begin
			state_d = cfg_hdr_pkg::LC_IDLE;
		end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= cfg_hdr_pkg::LC_IDLE;
			count_q <= cfg_hdr_pkg::BYTE_ZERO;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
		end
	end

	assign expired = state_q == cfg_hdr_pkg::LC_EXPIRED;
	assign end_request = expired && frame_active && !grant_active;
endmodule

/* design/pci_config_header_regs.sv */
// Purpose: Configuration header bank for latency, windows, subsystem id
// Assumes: Config access decoded upstream; one-cycle write/read strobes
// Notes:   Read data registered one cycle after the read strobe
`timescale 1ns/10ps
module pci_config_header_regs (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Configuration access
	input  wire logic        cfg_write,
	input  wire logic        cfg_read,
	input  wire logic [7:0]  cfg_offset,
	input  wire logic [3:0]  cfg_byte_en,
	input  wire logic [31:0] cfg_wdata,
	output logic [31:0]      cfg_rdata,
	// EEPROM loader
	input  wire logic        sid_load,
	input  wire logic [15:0] sid_value,
	// Command register state
	input  wire logic        memory_access_enable,
	// Master status
	input  wire logic        frame_active,
	input  wire logic        grant_active,
	output logic             master_end_req,
	output logic             bus_hold_expired,
	// Window decode
	input  wire logic        mem_access,
	input  wire logic [31:0] mem_addr,
	input  wire logic        io_access,
	input  wire logic [31:0] io_addr,
	output logic             mem_window_hit,
	output logic             io_window_hit,
	output logic             rom_window_hit,
	output logic [1:0]       cache_align
);
	logic [7:0]  bus_hold_limit_q;
	logic [7:0]  line_size_dw_q;
	logic [24:0] io_window_base_q;
	logic [24:0] memory_window_base_q;
	logic [15:0] subsystem_identifier_q;
	logic [14:0] rom_base_q;
	logic        rom_enable_q;
	logic [31:0] rdata_q;
	logic        end_q;
	logic        exp_q;
	logic        mem_hit_q;
	logic        io_hit_q;
	logic        rom_hit_q;
	logic [1:0]  align_q;
	wire         cnt_expired;
	wire         cnt_end;
	wire         space_kind_flag;
	wire  [31:0] lat_word;
	wire  [31:0] io_word;
	wire  [31:0] mem_word;
	wire  [31:0] sid_word;
	wire  [31:0] rom_word;
	wire  [31:0] rdata_d;
	wire  [31:0] merged;
	wire  [1:0]  align_d;
	wire         wr_lat;
	wire         wr_io;
	wire         wr_mem;
	wire         wr_rom;

	// Merge write data with current word by byte enables
	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
		input logic [31:0] neu, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = neu[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// Latency counter
	// ----------------------------------------
	bus_hold_counter u_counter (
		.core_clk     (core_clk),
		.reset        (reset),
		.frame_active (frame_active),
		.grant_active (grant_active),
		.limit        (bus_hold_limit_q),
		.expired      (cnt_expired),
		.end_request  (cnt_end)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign wr_lat = cfg_write && cfg_offset == cfg_hdr_pkg::OFF_LAT_CLS;
	assign wr_io  = cfg_write && cfg_offset == cfg_hdr_pkg::OFF_IO_BASE;
	assign wr_mem = cfg_write && cfg_offset == cfg_hdr_pkg::OFF_MEM_BASE;
	assign wr_rom = cfg_write && cfg_offset == cfg_hdr_pkg::OFF_ROM_BASE;
	assign space_kind_flag = 1'b1;
	assign lat_word = {16'h0000, bus_hold_limit_q, line_size_dw_q};
	assign io_word  = {io_window_base_q, 6'h00, space_kind_flag};
	assign mem_word = {memory_window_base_q, 7'h00};
	assign sid_word = {subsystem_identifier_q, 16'h0000};
	assign rom_word = {rom_base_q, 16'h0000, rom_enable_q};
	assign rdata_d  =
		(cfg_offset == cfg_hdr_pkg::OFF_LAT_CLS)  ? lat_word :
		(cfg_offset == cfg_hdr_pkg::OFF_IO_BASE)  ? io_word  :
		(cfg_offset == cfg_hdr_pkg::OFF_MEM_BASE) ? mem_word :
		(cfg_offset == cfg_hdr_pkg::OFF_SUBSYS)   ? sid_word :
		(cfg_offset == cfg_hdr_pkg::OFF_ROM_BASE) ? rom_word :
		cfg_hdr_pkg::ZERO_WORD;
	assign merged = merge_bytes(rdata_d, cfg_wdata, cfg_byte_en);
	// Unsupported sizes leave alignment off
	assign align_d =
		(line_size_dw_q == cfg_hdr_pkg::CLS_8)  ? cfg_hdr_pkg::ALIGN_8  :
		(line_size_dw_q == cfg_hdr_pkg::CLS_16) ? cfg_hdr_pkg::ALIGN_16 :
		(line_size_dw_q == cfg_hdr_pkg::CLS_32) ? cfg_hdr_pkg::ALIGN_32 :
		cfg_hdr_pkg::ALIGN_NONE;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bus_hold_limit_q     <= cfg_hdr_pkg::LAT_RESET;
			line_size_dw_q       <= cfg_hdr_pkg::CLS_RESET;
		end else if (wr_lat) begin
			bus_hold_limit_q     <= merged[cfg_hdr_pkg::LAT_LSB +: 8];
			line_size_dw_q       <= merged[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			io_window_base_q     <= cfg_hdr_pkg::BASE_ZERO;
			memory_window_base_q <= cfg_hdr_pkg::BASE_ZERO;
		end else begin
			if (wr_io) begin
				io_window_base_q     <= merged[31:cfg_hdr_pkg::BASE_LSB];
			end
			if (wr_mem) begin
				memory_window_base_q <= merged[31:cfg_hdr_pkg::BASE_LSB];
			end
		end
	end

	// ROM base kept for host setup
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rom_base_q   <= cfg_hdr_pkg::ROM_ZERO;
			rom_enable_q <= 1'b0;
		end else if (wr_rom) begin
			rom_base_q   <= merged[31:cfg_hdr_pkg::ROM_LSB];
			rom_enable_q <= merged[0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			subsystem_identifier_q <= cfg_hdr_pkg::SID_ZERO;
		end else if (sid_load) begin
			subsystem_identifier_q <= sid_value;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_q   <= cfg_hdr_pkg::ZERO_WORD;
			end_q     <= 1'b0;
			exp_q     <= 1'b0;
			mem_hit_q <= 1'b0;
			io_hit_q  <= 1'b0;
			rom_hit_q <= 1'b0;
			align_q   <= cfg_hdr_pkg::ALIGN_NONE;
		end else begin
			rdata_q   <= cfg_read ? rdata_d : cfg_hdr_pkg::ZERO_WORD;
			end_q     <= cnt_end;
			exp_q     <= cnt_expired;
			mem_hit_q <= mem_access && memory_access_enable &&
				mem_addr[31:7] == memory_window_base_q;
			io_hit_q  <= io_access && io_addr[31:7] == io_window_base_q;
			rom_hit_q <= mem_access && memory_access_enable &&
				rom_enable_q && mem_addr[31:17] == rom_base_q;
			align_q   <= align_d;
		end
	end

	assign cfg_rdata        = rdata_q;
	assign master_end_req   = end_q;
	assign bus_hold_expired = exp_q;
	assign mem_window_hit   = mem_hit_q;
	assign io_window_hit    = io_hit_q;
	assign rom_window_hit   = rom_hit_q;
	assign cache_align      = align_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_lat_reset_value: assert property (@(posedge core_clk)
		$fell(reset) |-> lat_word[15:0] ==
		{cfg_hdr_pkg::LAT_RESET, cfg_hdr_pkg::CLS_RESET})
		else $error("latency/line size reset wrong");
	a_io_flag_one: assert property (@(posedge core_clk)
		disable iff (reset) cfg_read &&
		cfg_offset == cfg_hdr_pkg::OFF_IO_BASE
		|=> cfg_rdata[0] == 1'b1)
		else $error("io indicator not one");
	a_mem_flag_zero: assert property (@(posedge core_clk)
		disable iff (reset) cfg_read &&
		cfg_offset == cfg_hdr_pkg::OFF_MEM_BASE
		|=> cfg_rdata[6:0] == 7'h00)
		else $error("memory low bits not zero");
	a_io_base_write: assert property (@(posedge core_clk)
		disable iff (reset) wr_io && cfg_byte_en == 4'hf
		|=> io_window_base_q == $past(cfg_wdata[31:7]))
		else $error("io base not written");
	a_lat_reserved: assert property (@(posedge core_clk)
		disable iff (reset) cfg_read &&
		cfg_offset == cfg_hdr_pkg::OFF_LAT_CLS
		|=> cfg_rdata[31:16] == 16'h0000)
		else $error("reserved bits nonzero");
	a_sid_loaded: assert property (@(posedge core_clk)
		disable iff (reset) sid_load ##1 (cfg_read &&
		cfg_offset == cfg_hdr_pkg::OFF_SUBSYS && !sid_load)
		|=> cfg_rdata[31:16] == $past(sid_value, 2))
		else $error("subsystem id not loaded");
	a_mem_gated: assert property (@(posedge core_clk)
		disable iff (reset) !memory_access_enable |=> !mem_window_hit)
		else $error("memory window hit while disabled");
	a_end_needs_exp: assert property (@(posedge core_clk)
		disable iff (reset) master_end_req |-> $past(cnt_expired) &&
		!$past(grant_active) && $past(frame_active))
		else $error("end request without expiry");
	a_count_starts: assert property (@(posedge core_clk)
		disable iff (reset) u_counter.state_q == cfg_hdr_pkg::LC_IDLE &&
		frame_active |=> u_counter.state_q == cfg_hdr_pkg::LC_COUNT)
		else $error("counter did not start");
endmodule

/* testbench/arbiter_model.sv */
// Purpose: Arbiter and master-frame model facing the bus-hold counter
// Assumes: Grant and frame are same-clock levels
// Notes:   Grant is withdrawn grant_len + 1 cycles after start; never early
`timescale 1ns/10ps
module arbiter_model (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// Bench control
	input  wire logic       start,
	input  wire logic [7:0] grant_len,
	// Device side
	input  wire logic       master_end_req,
	output logic            frame_active,
	output logic            grant_active
);
	logic [7:0] cnt_q;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			frame_active <= 1'b0;
			grant_active <= 1'b0;
			cnt_q        <= 8'h00;
		end else if (start) begin
			frame_active <= 1'b1;
			grant_active <= 1'b1;
			cnt_q        <= grant_len;
		end else begin
			if (cnt_q != 8'h00)
				cnt_q <= cnt_q - 8'h01;
			else
				grant_active <= 1'b0;
			if (master_end_req)
				frame_active <= 1'b0;
		end
	end
endmodule

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the configuration header bank
// Assumes: 40 MHz clock, synchronous reset held 8 cycles
// Notes:   Small latency limit keeps the bus-hold run short
`timescale 1ns/10ps
module tb_top;
	logic        core_clk, reset, cfg_write, cfg_read, sid_load;
	logic [7:0]  cfg_offset;
	logic [3:0]  cfg_byte_en;
	logic [31:0] cfg_wdata, cfg_rdata, mem_addr, io_addr;
	logic [15:0] sid_value;
	logic        memory_access_enable, frame_active, grant_active;
	logic        master_end_req, bus_hold_expired, mem_access, io_access;
	logic        mem_window_hit, io_window_hit, rom_window_hit, start;
	logic [1:0]  cache_align;
	int          error_cnt, num_checks;

	pci_config_header_regs pci_config_header_regs_i (
		.core_clk             (core_clk),
		.reset                (reset),
		.cfg_write            (cfg_write),
		.cfg_read             (cfg_read),
		.cfg_offset           (cfg_offset),
		.cfg_byte_en          (cfg_byte_en),
		.cfg_wdata            (cfg_wdata),
		.cfg_rdata            (cfg_rdata),
		.sid_load             (sid_load),
		.sid_value            (sid_value),
		.memory_access_enable (memory_access_enable),
		.frame_active         (frame_active),
		.grant_active         (grant_active),
		.master_end_req       (master_end_req),
		.bus_hold_expired     (bus_hold_expired),
		.mem_access           (mem_access),
		.mem_addr             (mem_addr),
		.io_access            (io_access),
		.io_addr              (io_addr),
		.mem_window_hit       (mem_window_hit),
		.io_window_hit        (io_window_hit),
		.rom_window_hit       (rom_window_hit),
		.cache_align          (cache_align)
	);
	arbiter_model arbiter_model_i (.core_clk(core_clk), .reset(reset),
		.start(start), .grant_len(8'h14), .master_end_req(master_end_req),
		.frame_active(frame_active), .grant_active(grant_active));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task wr(input logic [7:0] o, input logic [3:0] be, input logic [31:0] d);
		@(posedge core_clk);
		cfg_write <= 1'b1; cfg_offset <= o; cfg_byte_en <= be; cfg_wdata <= d;
		@(posedge core_clk);
		cfg_write <= 1'b0;
	endtask

	task rd(input logic [7:0] o, input logic [31:0] exp);
		@(posedge core_clk);
		cfg_read <= 1'b1; cfg_offset <= o;
		@(posedge core_clk);
		cfg_read <= 1'b0;
		#1 chk(cfg_rdata, exp, "read");
	endtask

	task acc(input logic m, input logic [31:0] a, input logic [2:0] exp);
		@(posedge core_clk);
		mem_access <= m; io_access <= !m; mem_addr <= a; io_addr <= a;
		@(posedge core_clk);
		mem_access <= 1'b0; io_access <= 1'b0;
		#1 chk({29'h0, mem_window_hit, io_window_hit, rom_window_hit},
			{29'h0, exp}, "window hit");
	endtask

	task t_reset_values;
		rd(8'h0c, 32'h0000_4008);
		rd(8'h10, 32'h0000_0001);
		rd(8'h14, 32'h0000_0000);
		rd(8'h30, 32'h0000_0000);
		chk({30'h0, cache_align}, 32'h0000_0001, "align");
	endtask

	task t_full_writes;
		wr(8'h0c, 4'hf, 32'hffff_ffff);
		rd(8'h0c, 32'h0000_ffff);
		wr(8'h10, 4'hf, 32'hffff_fffe);
		rd(8'h10, 32'hffff_ff81);
		wr(8'h14, 4'hf, 32'hffff_ffff);
		rd(8'h14, 32'hffff_ff80);
		wr(8'h2c, 4'hf, 32'hffff_ffff);
		rd(8'h2c, 32'h0000_0000);
		wr(8'h18, 4'hf, 32'hffff_ffff);
		rd(8'h18, 32'h0000_0000);
		wr(8'h30, 4'hf, 32'hffff_ffff);
		rd(8'h30, 32'hfffe_0001);
	endtask

	task t_line_sizes;
		logic [7:0] sz [4];
		sz = '{8'h08, 8'h10, 8'h20, 8'h04};
		for (int i = 0; i < 4; i++) begin
			wr(8'h0c, 4'h1, {24'h0, sz[i]});
			@(posedge core_clk);
			#1 chk({30'h0, cache_align}, (i + 1) % 4, "align");
		end
		rd(8'h0c, 32'h0000_ff04);
	endtask

	task t_sid_load;
		@(posedge core_clk);
		sid_load <= 1'b1; sid_value <= 16'h5a3c;
		@(posedge core_clk);
		sid_load <= 1'b0; cfg_read <= 1'b1; cfg_offset <= 8'h2c;
		@(posedge core_clk);
		cfg_read <= 1'b0;
		#1 chk(cfg_rdata, 32'h5a3c_0000, "sid next read");
		rd(8'h2c, 32'h5a3c_0000);
	endtask

	task t_windows;
		wr(8'h10, 4'hf, 32'h0000_1080);
		wr(8'h14, 4'hf, 32'h2000_0100);
		// boot ROM base set before use
		wr(8'h30, 4'hf, 32'h0004_0001);
		memory_access_enable <= 1'b1;
		acc(1'b1, 32'h2000_0104, 3'b100);
		acc(1'b1, 32'h0004_0010, 3'b001);
		acc(1'b0, 32'h0000_10a0, 3'b010);
		acc(1'b0, 32'h0000_1100, 3'b000);
		memory_access_enable <= 1'b0;
		acc(1'b1, 32'h2000_0104, 3'b000);
		acc(1'b1, 32'h0004_0010, 3'b000);
	endtask

	task t_bus_hold;
		int n;
		wr(8'h0c, 4'h2, 32'h0000_0400);
		repeat (10) @(posedge core_clk);
		#1 chk({31'h0, bus_hold_expired}, 32'h0, "idle expiry");
		@(posedge core_clk);
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		#1 chk({31'h0, bus_hold_expired}, 32'h0, "early expiry");
		n = 0;
		while (bus_hold_expired !== 1'b1 && n < 8) begin
			@(posedge core_clk);
			#1 n++;
		end
		chk({31'h0, bus_hold_expired}, 32'h1, "expiry");
		chk({31'h0, master_end_req}, 32'h0, "end with grant");
		wait (grant_active === 1'b0);
		@(posedge core_clk);
		#1 chk({31'h0, master_end_req}, 32'h1, "end raised");
		repeat (2) @(posedge core_clk);
		#1 chk({31'h0, frame_active}, 32'h0, "end request");
	endtask

	task final_report;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		{reset, cfg_write, cfg_read, sid_load, start} = 5'b1_0000;
		{cfg_offset, cfg_byte_en, cfg_wdata, sid_value} = '0;
		{memory_access_enable, mem_access, io_access} = 3'b000;
		{mem_addr, io_addr} = '0;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		#1 t_reset_values();
		t_full_writes();
		t_line_sizes();
		t_sid_load();
		t_windows();
		t_bus_hold();
		final_report();
	end

	// Watchdog at 4000 cycles, well past the roughly 120 cycles the run needs
	initial begin
		#100000;
		error_cnt++;
		final_report();
	end
endmodule
